// >>> rtl/hbridge_pwm_output_stage.sv
// Purpose: three-pair waveform generator with h-bridge output selector
// Assumes: avalon-mm slave, one wait cycle per access, 16-bit registers
// Notes:   outputs lag the internal waves by one register stage
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module hbridge_pwm_output_stage (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [31:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output      logic [31:0] readdata,
    output      logic        waitrequest,
    // power stage side
    input  wire logic        trip_input,
    output      logic [5:0]  wave_out,
    output      logic [5:0]  pin_wave_sel,
    output      logic        irq
);

    localparam int NP = hbridge_pwm_pkg::NUM_PAIRS;

    // bus state
    logic [31:0] next_readdata;
    logic        next_waitrequest;
    logic        wr_fire;
    logic [15:0] wmask;

    // register state
    hbridge_pwm_pkg::ctrl_t     ctrl;
    hbridge_pwm_pkg::ctrl_t     next_ctrl;
    hbridge_pwm_pkg::pair_cfg_t cfg        [NP];
    hbridge_pwm_pkg::pair_cfg_t next_cfg   [NP];
    logic                       pending;
    logic                       next_pending;
    logic [5:0]                 next_pin_wave_sel;
    logic                       next_irq;

    // timer state
    logic [7:0]                 div_count;
    logic [7:0]                 next_div_count;
    logic [7:0]                 div_mask;
    logic                       tick;
    logic [15:0]                timer;
    logic [15:0]                next_timer;
    logic                       step;
    logic                       next_step;
    hbridge_pwm_pkg::pair_cfg_t shadow      [NP];
    hbridge_pwm_pkg::pair_cfg_t next_shadow [NP];

    // waveform state
    hbridge_pwm_pkg::pair_wave_t wave [NP];
    logic [5:0]                  next_wave_out;
    logic                        hs;
    logic                        ls;

    // masks a 16-bit write by the two low byte lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [15:0] mask
    );
        merge16 = (old_v & ~mask) | (new_v & mask);
    endfunction

    // ---------------------------------------------------------------
    // bus handshake: waitrequest rests high, drops for one cycle
    // ---------------------------------------------------------------
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata    = readdata;
        wr_fire          = write && !waitrequest;
        wmask            = {{8{byteenable[1]}}, {8{byteenable[0]}}};
        if ((read || write) && waitrequest) begin
            next_waitrequest = 1'b0;
            next_readdata    = 32'h0000_0000;
            if (read) begin
                if (address == hbridge_pwm_pkg::ADDR_CONTROL) begin
                    next_readdata[15:0] = ctrl;
                end
                if (address == hbridge_pwm_pkg::ADDR_TIMER) begin
                    next_readdata[15:0] = timer;
                end
                if (address == hbridge_pwm_pkg::ADDR_STATUS) begin
                    next_readdata[hbridge_pwm_pkg::STAT_PENDING_BIT] =
                        pending;
                    next_readdata[hbridge_pwm_pkg::STAT_TRIP_BIT] =
                        trip_input;
                end
                if (address == hbridge_pwm_pkg::ADDR_PIN_FUNC) begin
                    next_readdata[5:0] = pin_wave_sel;
                end
                for (int i = 0; i < NP; i++) begin
                    if (address == hbridge_pwm_pkg::ADDR_RISE[i]) begin
                        next_readdata[15:0] = cfg[i].rise;
                    end
                    if (address == hbridge_pwm_pkg::ADDR_FALL[i]) begin
                        next_readdata[15:0] = cfg[i].fall;
                    end
                    if (address == hbridge_pwm_pkg::ADDR_LOW_FALL[i]) begin
                        next_readdata[15:0] = cfg[i].low_fall;
                    end
                    if (address == hbridge_pwm_pkg::ADDR_LENGTH[i]) begin
                        next_readdata[15:0] = cfg[i].length;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // register writes, trip and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        next_ctrl         = ctrl;
        next_pending      = pending;
        next_pin_wave_sel = pin_wave_sel;
        for (int i = 0; i < NP; i++) begin
            next_cfg[i] = cfg[i];
        end
        if (wr_fire) begin
            if (address == hbridge_pwm_pkg::ADDR_CONTROL) begin
                next_ctrl = merge16(ctrl, writedata[15:0],
                    wmask & hbridge_pwm_pkg::CTRL_WRITE_MASK);
            end
            if (address == hbridge_pwm_pkg::ADDR_PIN_FUNC) begin
                next_pin_wave_sel = 6'(merge16({10'h000, pin_wave_sel},
                    writedata[15:0], wmask));
            end
            if (address == hbridge_pwm_pkg::ADDR_IRQ_CLEAR) begin
                // data ignored: the write itself is the clear
                next_pending = 1'b0;
            end
            for (int i = 0; i < NP; i++) begin
                if (address == hbridge_pwm_pkg::ADDR_RISE[i]) begin
                    next_cfg[i].rise =
                        merge16(cfg[i].rise, writedata[15:0], wmask);
                end
                if (address == hbridge_pwm_pkg::ADDR_FALL[i]) begin
                    next_cfg[i].fall =
                        merge16(cfg[i].fall, writedata[15:0], wmask);
                end
                if (address == hbridge_pwm_pkg::ADDR_LOW_FALL[i]) begin
                    next_cfg[i].low_fall =
                        merge16(cfg[i].low_fall, writedata[15:0], wmask);
                end
                if (address == hbridge_pwm_pkg::ADDR_LENGTH[i]) begin
                    next_cfg[i].length =
                        merge16(cfg[i].length, writedata[15:0], wmask);
                end
            end
        end
        // trip is level sensitive, so a handler that leaves it low
        // sees the interrupt stay pending through its clear
        if (ctrl.trip_enable && !trip_input) begin
            next_ctrl.master_output_enable = 1'b0;
            next_pending                   = 1'b1;
        end
        next_irq = next_pending;
    end

    // ---------------------------------------------------------------
    // prescaler, shared timer and compare load
    // ---------------------------------------------------------------
    always_comb begin
        div_mask       = 8'(({1'b0, 8'h02} << ctrl.clock_prescale_sel)
                            - 9'h001);
        tick           = (div_count & div_mask) == div_mask;
        next_div_count = 8'(div_count + 8'h01);
        next_timer     = timer;
        next_step      = 1'b0;
        for (int i = 0; i < NP; i++) begin
            next_shadow[i] = shadow[i];
        end
        if (!ctrl.master_output_enable) begin
            next_div_count = 8'h00;
            next_timer     = 16'h0000;
        end else if (tick) begin
            next_step = 1'b1;
            // wrap on the live length so a zero working set can start
            if (timer == cfg[0].length) begin
                next_timer = 16'h0000;
            end else begin
                next_timer = 16'(timer + 16'h0001);
            end
            if (timer == 16'h0000 && next_timer == 16'h0001 &&
                ctrl.compare_load) begin
                for (int i = 0; i < NP; i++) begin
                    next_shadow[i] = cfg[i];
                end
            end
        end
    end

    generate
        for (genvar g = 0; g < NP; g++) begin : gen_pair
            wave_pair u_pair (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .clear   (!ctrl.master_output_enable),
                .step    (step),
                .timer   (timer),
                .cfg     (shadow[g]),
                .wave    (wave[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // output selector
    // ---------------------------------------------------------------
    always_comb begin
        hs = wave[0].high_side_wave;
        ls = wave[0].low_side_wave;
        for (int i = 0; i < NP; i++) begin
            next_wave_out[2*i]   = wave[i].high_side_wave;
            next_wave_out[2*i+1] = wave[i].low_side_wave ^
                                   ctrl.odd_invert[i];
        end
        if (ctrl.bridge_mode) begin
            if (ctrl.high_side_off) begin
                next_wave_out[3:0] = 4'h5;
            end else if (!ctrl.bridge_output_enable) begin
                next_wave_out[3:0] = 4'hf;
            end else begin
                case ({ctrl.invert_all_outputs, ctrl.direction})
                    2'b00: next_wave_out[3:0] = {ls, hs, 2'b00};
                    2'b01: next_wave_out[3:0] = {2'b00, ls, hs};
                    2'b10: next_wave_out[3:0] = {2'b11, ls, hs};
                    2'b11: next_wave_out[3:0] = {ls, hs, 2'b11};
                    default: next_wave_out[3:0] = 4'h5;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            readdata     <= 32'h0000_0000;
            waitrequest  <= 1'b1;
            ctrl         <= hbridge_pwm_pkg::CTRL_RESET;
            pending      <= 1'b0;
            irq          <= 1'b0;
            pin_wave_sel <= hbridge_pwm_pkg::PIN_FUNC_RESET;
            div_count    <= 8'h00;
            timer        <= 16'h0000;
            step         <= 1'b0;
            wave_out     <= 6'h00;
            for (int i = 0; i < NP; i++) begin
                cfg[i]    <= {4{hbridge_pwm_pkg::CMP_RESET}};
                shadow[i] <= {4{hbridge_pwm_pkg::CMP_RESET}};
            end
        end else begin
            readdata     <= next_readdata;
            waitrequest  <= next_waitrequest;
            ctrl         <= next_ctrl;
            pending      <= next_pending;
            irq          <= next_irq;
            pin_wave_sel <= next_pin_wave_sel;
            div_count    <= next_div_count;
            timer        <= next_timer;
            step         <= next_step;
            wave_out     <= next_wave_out;
            for (int i = 0; i < NP; i++) begin
                cfg[i]    <= next_cfg[i];
                shadow[i] <= next_shadow[i];
            end
        end
    end

endmodule

// >>> rtl/hbridge_pwm_pkg.sv
// Purpose: shared constants and types of the h-bridge waveform stage
// Assumes: 32-bit avalon byte addresses, 16-bit registers in low lanes
// Notes:   per-pair tables are indexed by pair number 0..2
package hbridge_pwm_pkg;

    localparam int NUM_PAIRS = 3;

    // register byte addresses
    localparam logic [31:0] ADDR_CONTROL   = 32'hffff0f80;
    localparam logic [31:0] ADDR_TIMER     = 32'hffff0fb4;
    localparam logic [31:0] ADDR_STATUS    = 32'hffff0fbc;
    localparam logic [31:0] ADDR_PIN_FUNC  = 32'hffff0fc0;
    localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h00ffffb8;

    localparam logic [31:0] ADDR_RISE [NUM_PAIRS] =
        '{32'hffff0f84, 32'hffff0f94, 32'hffff0fa4};
    localparam logic [31:0] ADDR_FALL [NUM_PAIRS] =
        '{32'hffff0f88, 32'hffff0f98, 32'hffff0fa8};
    localparam logic [31:0] ADDR_LOW_FALL [NUM_PAIRS] =
        '{32'hffff0f8c, 32'hffff0f9c, 32'hffff0fac};
    localparam logic [31:0] ADDR_LENGTH [NUM_PAIRS] =
        '{32'h0fffff90, 32'h0fffffa0, 32'h0fffffb0};

    // reset values and control write mask
    localparam logic [15:0] CTRL_RESET      = 16'h0012;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h3fff;
    localparam logic [15:0] CMP_RESET       = 16'h0000;
    localparam logic [5:0]  PIN_FUNC_RESET  = 6'h3f;

    // status field positions
    localparam int STAT_PENDING_BIT = 0;
    localparam int STAT_TRIP_BIT    = 1;

    // control register layout, bit 15 down to bit 0
    typedef struct packed {
        logic [1:0] reserved;
        logic [2:0] odd_invert;
        logic       trip_enable;
        logic       bridge_output_enable;
        logic [2:0] clock_prescale_sel;
        logic       invert_all_outputs;
        logic       high_side_off;
        logic       compare_load;
        logic       direction;
        logic       bridge_mode;
        logic       master_output_enable;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] low_fall;
        logic [15:0] length;
    } pair_cfg_t;

    typedef struct packed {
        logic high_side_wave;
        logic low_side_wave;
    } pair_wave_t;

endpackage

// >>> rtl/wave_pair.sv
// Purpose: one high-side / low-side waveform pair
// Assumes: step pulses in the cycle after the shared timer moved
// Notes:   clear holds both waves low while the unit is disabled
`timescale 1ns/1ps
module wave_pair (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    // timer side
    input  wire logic                      clear,
    input  wire logic                      step,
    input  wire logic [15:0]               timer,
    input  wire hbridge_pwm_pkg::pair_cfg_t cfg,
    // waveforms
    output      hbridge_pwm_pkg::pair_wave_t wave
);

    hbridge_pwm_pkg::pair_wave_t next_wave;

    always_comb begin
        next_wave = wave;
        if (clear) begin
            next_wave = '0;
        end else if (step) begin
            if (timer == cfg.rise) begin
                next_wave.high_side_wave = 1'b1;
            end
            // fall checked last so it wins a tie with rise
            if (timer == cfg.fall) begin
                next_wave.high_side_wave = 1'b0;
            end
            if (timer == cfg.length) begin
                next_wave.low_side_wave = 1'b1;
            end
            if (timer == cfg.low_fall) begin
                next_wave.low_side_wave = 1'b0;
            end
            if (wave.high_side_wave && !next_wave.high_side_wave) begin
                next_wave.low_side_wave = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wave <= '0;
        end else begin
            wave <= next_wave;
        end
    end

endmodule

// >>> tb/hbridge_pwm_chk.sv
// Purpose: port-level checker for the h-bridge waveform stage
// Assumes: one wait cycle per access, irq set and cleared with pending
// Notes:   waveform timing is judged by the bench, the timer is internal
`timescale 1ns/1ps
module hbridge_pwm_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // register bus
    input wire logic [31:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // power stage side
    input wire logic        trip_input,
    input wire logic [5:0]  wave_out,
    input wire logic [5:0]  pin_wave_sel,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("request not answered after one wait cycle");

    property p_wait_pulse;
        !waitrequest |=> waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");

    property p_idle_wait;
        !read && !write && waitrequest |=> waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("waitrequest dropped without a request");

    property p_upper_zero;
        !waitrequest |-> readdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read lanes not zero");

    property p_reset_out;
        $rose(rst_b) |-> pin_wave_sel == 6'h3f && !irq && waitrequest;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs wrong right after reset");

    // no request is expected this early, so the pattern must be the default
    property p_high_side_off_boot;
        $rose(rst_b) |-> ##2 wave_out[3:0] == 4'h5;
    endproperty
    a_high_side_off_boot: assert property (p_high_side_off_boot)
        else $error("bridge outputs not in high-side-off pattern");

    property p_irq_rise;
        $rose(irq) |-> $past(trip_input) == 1'b0;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose without a trip");

    property p_irq_clear;
        write && !waitrequest && trip_input
            && address == hbridge_pwm_pkg::ADDR_IRQ_CLEAR |-> ##1 !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("irq still high after clear write");

    property p_irq_fall;
        $fell(irq) |-> $past(write) && !$past(waitrequest)
            && $past(address) == hbridge_pwm_pkg::ADDR_IRQ_CLEAR;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without a clear write");

    property p_ls_drop;
        ($fell(wave_out[0]) |-> !wave_out[1])
            and ($fell(wave_out[2]) |-> !wave_out[3]);
    endproperty
    a_ls_drop: assert property (p_ls_drop)
        else $error("low side stayed high as high side fell");
endmodule

bind hbridge_pwm_output_stage hbridge_pwm_chk u_chk (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .address     (address),
    .read        (read),
    .write       (write),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .trip_input  (trip_input),
    .wave_out    (wave_out),
    .pin_wave_sel(pin_wave_sel),
    .irq         (irq)
);

// >>> tb/hbridge_pwm_output_stage_tb.sv
// Purpose: self-checking bench for the h-bridge waveform stage
// Assumes: one wait cycle per access, standard mode for duty runs
// Notes:   duty windows span whole periods so start phase does not matter
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module hbridge_pwm_output_stage_tb;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        fault_req = 1'b0;
    logic [31:0] address = 32'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        trip_input;
    logic        irq;
    logic [5:0]  wave_out;
    logic [5:0]  pin_wave_sel;
    logic [31:0] rng = 32'h08ecb92f;
    logic [15:0] mon_exp;
    logic [15:0] exp_q[$];
    int          fail_count = 0;
    int          num_checks = 0;
    int          cnt[6];
    int          rise[3] = '{2, 1, 3};
    int          fall[3] = '{5, 6, 4};
    int          lowf[3] = '{6, 2, 2};
    int          len[3] = '{7, 7, 0};
    int          duty[6] = '{24, 48, 40, 24, 8, 16};
    logic [15:0] modes[6] = '{16'h0236, 16'h0002, 16'h0202,
                              16'h0206, 16'h0222, 16'h0226};
    logic [3:0]  pats[6] = '{4'h5, 4'hf, 4'h0, 4'h0, 4'hc, 4'h3};

    always #25 sys_clk = ~sys_clk;

    hbridge_pwm_output_stage dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h3), .readdata(readdata),
        .waitrequest(waitrequest), .trip_input(trip_input),
        .wave_out(wave_out), .pin_wave_sel(pin_wave_sel), .irq(irq)
    );

    hbridge_stage_model u_stage (
        .sys_clk(sys_clk), .fault_req(fault_req), .trip_input(trip_input)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // request held until waitrequest is seen low, then released
    task automatic bus(input logic rd, input logic [31:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= {16'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            complete_run();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 16'h0);
    endtask

    task automatic measure(input int win);
        cnt = '{default: 0};
        repeat (win) begin
            @(posedge sys_clk);
            for (int k = 0; k < 6; k++) begin
                if (wave_out[k] === 1'b1) begin
                    cnt[k]++;
                end
            end
        end
    endtask

    always @(posedge sys_clk) begin
        if (read && waitrequest === 1'b0) begin
            mon_exp = exp_q.pop_front();
            `CHK(readdata, {16'h0, mon_exp})
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        int n;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(wave_out[3:0], 4'h5)
        rd(hbridge_pwm_pkg::ADDR_CONTROL, 16'h0012);
        rd(hbridge_pwm_pkg::ADDR_PIN_FUNC, 16'h003f);
        rd(32'hffff0f00, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            rd(hbridge_pwm_pkg::ADDR_RISE[i], 16'h0);
            rd(hbridge_pwm_pkg::ADDR_FALL[i], 16'h0);
            rd(hbridge_pwm_pkg::ADDR_LOW_FALL[i], 16'h0);
            rd(hbridge_pwm_pkg::ADDR_LENGTH[i], 16'h0);
            rng = xs(rng);
            bus(1'b0, hbridge_pwm_pkg::ADDR_LENGTH[i], rng[15:0]);
            rd(hbridge_pwm_pkg::ADDR_LENGTH[i], rng[15:0]);
            rng = xs(rng);
            bus(1'b0, hbridge_pwm_pkg::ADDR_RISE[i], rng[15:0]);
            rd(hbridge_pwm_pkg::ADDR_RISE[i], rng[15:0]);
        end
        for (int m = 0; m < 6; m++) begin
            bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, modes[m]);
            repeat (4) @(posedge sys_clk);
            `CHK(wave_out[3:0], pats[m])
        end
        $display("bridge table done");
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, hbridge_pwm_pkg::ADDR_RISE[i], 16'(rise[i]));
            bus(1'b0, hbridge_pwm_pkg::ADDR_FALL[i], 16'(fall[i]));
            bus(1'b0, hbridge_pwm_pkg::ADDR_LOW_FALL[i], 16'(lowf[i]));
            bus(1'b0, hbridge_pwm_pkg::ADDR_LENGTH[i], 16'(len[i]));
        end
        for (int s = 0; s < 8; s++) begin
            bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, 16'h0009 | 16'(s << 6));
            repeat (48 << s) @(posedge sys_clk);
            measure(64 << s);
            for (int p = 0; p < 3; p++) begin
                `CHK(cnt[2*p], duty[2*p] << s)
                `CHK(cnt[2*p+1], duty[2*p+1] << s)
            end
        end
        $display("duty and prescale done");
        // new fall value must wait for a load request
        bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, 16'h0001);
        bus(1'b0, hbridge_pwm_pkg::ADDR_FALL[0], 16'h0006);
        repeat (48) @(posedge sys_clk);
        measure(64);
        `CHK(cnt[0], 24)
        bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, 16'h0009);
        repeat (48) @(posedge sys_clk);
        measure(64);
        `CHK(cnt[0], 32)
        $display("compare load done");
        // stop first so no output falls while its partner is still high
        bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, 16'h0000);
        for (int m = 0; m < 2; m++) begin
            bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, m ? 16'h0227 : 16'h0203);
            repeat (48) @(posedge sys_clk);
            measure(64);
            `CHK(cnt[0], m ? 64 : 0)
            `CHK(cnt[1], m ? 64 : 0)
            `CHK(cnt[2], 32)
            `CHK(cnt[3], 56)
        end
        bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, 16'h0000);
        $display("bridge waves done");
        bus(1'b0, hbridge_pwm_pkg::ADDR_CONTROL, 16'h0401);
        fault_req <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(irq, 1'b1)
        rd(hbridge_pwm_pkg::ADDR_CONTROL, 16'h0400);
        fault_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        rng = xs(rng);
        bus(1'b0, hbridge_pwm_pkg::ADDR_IRQ_CLEAR, rng[15:0]);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        rd(hbridge_pwm_pkg::ADDR_STATUS, 16'h0002);
        $display("trip and clear done");
        complete_run();
    end
endmodule

// >>> tb/hbridge_stage_model.sv
// Purpose: power stage model that reports a fault on request
// Assumes: fault sense is active low and synchronous to sys_clk
// Notes:   DELAY makes the fault appear promptly or late
`timescale 1ns/1ps
module hbridge_stage_model #(
    parameter int DELAY = 2
) (
    // clock
    input wire logic sys_clk,
    // fault command from the bench
    input wire logic fault_req,
    // fault sense back to the block
    output     logic trip_input
);
    int n = 0;

    initial trip_input = 1'b1;

    // a real stage needs time to detect over-current, hence the delay
    always @(posedge sys_clk) begin
        n <= fault_req ? n + 1 : 0;
        trip_input <= !(fault_req && n >= DELAY);
    end
endmodule
